/* hw/cps_pkg.sv */
// Package with register map, field layout, timing and types of the clock prescaler and sleep controller.
// Notes on behaviour
// - Select changes only while unlock bit set.
// - Unlock sets only when other bits zero.
// - Unlock clears after four cycles or select write.
// - Rewriting unlock neither extends nor clears window.
// - Select codes 0..8 divide by power two.
// - Divider slows core and synchronous peripherals.
// - Reset select 0000, or 0011 with fuse.
// - Any select writable regardless of fuse.
// - Sleep only on instruction with enable set.
// - Wake halts four cycles plus start-up.
// - Sleep preserves register file and memory.
// - Reset during sleep restarts from reset vector.
// - Mode field: 00 idle, x1 down, 10 standby; the code takes 10 as down unless ext_crystal_sel is high.
// - Idle stops only core and flash clocks.
// - Idle wakes on any enabled interrupt.
// - Power-down stops all clocks; few wake sources.
// - Power-down wake waits fuse-chosen start-up delay.
// - Standby keeps oscillator, wakes in six cycles.
`default_nettype none
package cps_pkg;
  // Byte addresses of the three registers on the bus.
  localparam logic [7:0] ADDR_DIV_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_SLEEP_CTRL = 8'h04;
  localparam logic [7:0] ADDR_STATUS     = 8'h08;
  // Field positions in the divider control register.
  localparam int UNLOCK_BIT = 7;
  localparam int SEL_LSB    = 0;
  localparam int SEL_W      = 4;
  // Field positions in the sleep control register.
  localparam int PULLUP_BIT = 7;
  localparam int MODE_HI    = 6;
  localparam int ENABLE_BIT = 5;
  localparam int MODE_LO    = 4;
  // Reset values and the largest select code.
  localparam logic [3:0] SEL_RST_PLAIN = 4'h0;
  localparam logic [3:0] SEL_RST_DIV8  = 4'h3;
  localparam logic [7:0] SLEEP_RST     = 8'h00;
  localparam logic [3:0] SEL_MAX       = 4'h8;
  // Timing counts in master clock cycles.
  localparam logic [2:0] UNLOCK_CYCLES  = 3'h4;
  localparam logic [2:0] HALT_CYCLES    = 3'h4;
  localparam logic [2:0] STANDBY_CYCLES = 3'h6;
  // Sleep mode codes as seen in the two-bit mode field.
  localparam logic [1:0] MODE_IDLE    = 2'h0;
  localparam logic [1:0] MODE_STANDBY = 2'h2;
  // Controller states, one-hot.
  typedef enum logic [4:0] {
    ST_RUN   = 5'h01,
    ST_IDLE  = 5'h02,
    ST_DOWN  = 5'h04,
    ST_START = 5'h08,
    ST_HALT  = 5'h10
  } cps_state_t;
  // Wake sources grouped together.
  typedef struct packed {
    logic ext_external_interrupt_zero_level;  // Level interrupt on external interrupt zero.
    logic ext_int_edge;    // Edge interrupts on either external interrupt.
    logic pin_change;      // Pin change interrupt.
    logic serial_start;    // Serial start-condition interrupt.
    logic mem_ready;       // Memory-ready interrupt.
    logic other_io;        // Timers, UART and other I/O interrupts.
  } cps_wake_t;
  // Clock gate enables toward the clock tree.
  typedef struct packed {
    logic cpu;    // Core clock enable.
    logic flash;  // Flash clock enable.
    logic io;     // I/O clock enable.
    logic osc;    // Oscillator run.
  } cps_clk_en_t;
endpackage
`default_nettype wire

/* hw/cps_top.sv */
// Clock prescaler with timed unlock, and sleep mode controller with an AHB-Lite slave.
`default_nettype none
module cps_top (
  input  wire logic             hclk,              // Master clock, 10 MHz.
  input  wire logic             hresetn,           // Chip reset, asynchronous, active low.
  input  wire logic             hsel,              // Slave select.
  input  wire logic [7:0]       haddr,             // Byte address.
  input  wire logic [1:0]       htrans,            // Transfer type.
  input  wire logic             hwrite,            // Write when high.
  input  wire logic [2:0]       hsize,             // Transfer size.
  input  wire logic [31:0]      hwdata,            // Write data.
  input  wire logic             hready,            // Bus ready in.
  output logic [31:0]           hrdata,            // Read data.
  output logic                  hreadyout,         // Slave ready.
  output logic                  hresp,             // Response, always OKAY.
  input  wire logic             divide_by_eight_fuse, // Fuse level, programmed when high.
  input  wire logic             ext_crystal_sel,   // Clock-source fuses select crystal or resonator.
  input  wire logic [7:0]       startup_cycles,    // Start-up delay chosen by clock-source fuses.
  input  wire logic             sleep_instr,       // Core executes the sleep instruction, one-cycle pulse.
  input  wire cps_pkg::cps_wake_t wake_req,        // Enabled wake-up requests, same clock.
  output logic                  clk_div_en,        // One-cycle enable at the divided rate.
  output cps_pkg::cps_clk_en_t  clk_en,            // Clock domain enables.
  output logic                  core_halt,         // Core stalled while asleep or waking.
  output logic                  pullup_disable     // Pull-up disable from the control register.
);

  // Divider and sleep controller state.
  logic [3:0]  sel_reg, sel_next;      // Division select field.
  logic        unlock_reg, unlock_next; // Change unlock bit.
  logic [2:0]  ucnt_reg, ucnt_next;    // Cycles since unlock was set.
  logic [7:0]  sleep_reg, sleep_next;  // Sleep and interrupt-sense control register.
  logic        fuse_sync1_reg;         // First stage of the fuse synchroniser.
  logic        fuse_sync2_reg;         // Second stage of the fuse synchroniser.
  logic        fuse_load_reg;          // High once the fuse level has been captured.
  logic [1:0]  fuse_wait_reg;          // Holds the load back until the second stage carries the fuse.
  logic [7:0]  div_cnt_reg;            // Prescaler counter, free-running except in ST_DOWN.
  logic        div_en_reg;             // Registered divided-rate enable.
  cps_pkg::cps_state_t state_reg, state_next; // Sleep controller state.
  logic [7:0]  wcnt_reg, wcnt_next;    // Wake delay counter.
  // Bus address-phase capture.
  logic        wr_pend_reg;            // Write data phase pending.
  logic [7:0]  addr_reg;               // Captured address.
  logic [31:0] rdata_reg;              // Registered read data.

  // Address phase is accepted when selected with an active transfer while hready is high.
  wire         bus_go     = hsel && hready && htrans[1];
  wire         rd_go      = bus_go && !hwrite;
  wire         wr_div     = wr_pend_reg && (addr_reg == cps_pkg::ADDR_DIV_CTRL);
  wire         wr_slp     = wr_pend_reg && (addr_reg == cps_pkg::ADDR_SLEEP_CTRL);
  wire [7:0]   wbyte      = hwdata[7:0];
  wire         wb_unlock  = wbyte[cps_pkg::UNLOCK_BIT];
  wire [3:0]   wb_sel     = wbyte[cps_pkg::SEL_LSB +: cps_pkg::SEL_W];
  // Unlock is only taken when every other bit of the write is zero.
  wire         unlock_wr  = wr_div && wb_unlock && (wbyte[6:0] == 7'h00);
  // A select write is one with the unlock bit clear while the window is open.
  wire         sel_wr     = wr_div && !wb_unlock && unlock_reg;
  wire [1:0]   mode       = {sleep_reg[cps_pkg::MODE_HI], sleep_reg[cps_pkg::MODE_LO]};
  wire         sleep_go   = sleep_instr && sleep_reg[cps_pkg::ENABLE_BIT];
  wire         wake_idle  = |wake_req;
  wire         wake_deep  = wake_req.ext_external_interrupt_zero_level || wake_req.pin_change || wake_req.serial_start;
  wire         is_standby = (mode == cps_pkg::MODE_STANDBY) && ext_crystal_sel;

  // Decode of the divider select into a counter mask; reserved codes hold the largest factor.
  function automatic logic [7:0] div_mask(input logic [3:0] s);
    logic [3:0] c;
    c = (s > cps_pkg::SEL_MAX) ? cps_pkg::SEL_MAX : s;
    div_mask = 8'((9'h001 << c) - 9'h001);
  endfunction

  wire [7:0] mask_now = div_mask(sel_reg);

  // Next state of the divider control register.
  always_comb begin
    sel_next    = sel_reg;
    unlock_next = unlock_reg;
    ucnt_next   = ucnt_reg;
    if (unlock_reg) begin
      ucnt_next = ucnt_reg + 3'h1;
      // Window closes after four cycles, never restarted by a rewrite.
      if (ucnt_next == cps_pkg::UNLOCK_CYCLES) begin
        unlock_next = 1'b0;
      end
    end
    if (sel_wr) begin
      sel_next    = wb_sel;
      unlock_next = 1'b0;
    end else if (unlock_wr && !unlock_reg) begin
      unlock_next = 1'b1;
      ucnt_next   = 3'h0;
    end
    if (!fuse_load_reg) begin
      sel_next = fuse_sync2_reg ? cps_pkg::SEL_RST_DIV8 : cps_pkg::SEL_RST_PLAIN;
    end
  end

  // Next value of the sleep control register; the pull-up bit is read only.
  always_comb begin
    sleep_next = sleep_reg;
    if (wr_slp) begin
      sleep_next = {1'b0, wbyte[6:0]};
    end
  end

  // Sleep controller; register file and memory are untouched since only clocks are gated.
  always_comb begin
    state_next = state_reg;
    wcnt_next  = wcnt_reg;
    unique case (state_reg)
      cps_pkg::ST_RUN: begin
        if (sleep_go) begin
          state_next = (mode == cps_pkg::MODE_IDLE) ? cps_pkg::ST_IDLE : cps_pkg::ST_DOWN;
        end
      end
      cps_pkg::ST_IDLE: begin
        if (wake_idle) begin
          state_next = cps_pkg::ST_HALT;
          wcnt_next  = 8'(cps_pkg::HALT_CYCLES);
        end
      end
      cps_pkg::ST_DOWN: begin
        if (wake_deep) begin
          state_next = cps_pkg::ST_START;
          wcnt_next  = is_standby ? 8'(cps_pkg::STANDBY_CYCLES) : startup_cycles;
        end
      end
      cps_pkg::ST_START: begin
        if (wcnt_reg <= 8'h01) begin
          state_next = cps_pkg::ST_HALT;
          wcnt_next  = 8'(cps_pkg::HALT_CYCLES);
        end else begin
          wcnt_next = wcnt_reg - 8'h01;
        end
      end
      cps_pkg::ST_HALT: begin
        if (wcnt_reg <= 8'h01) begin
          state_next = cps_pkg::ST_RUN;
          wcnt_next  = 8'h00;
        end else begin
          wcnt_next = wcnt_reg - 8'h01;
        end
      end
      default: begin
        state_next = cps_pkg::ST_RUN;
        wcnt_next  = 8'h00;
      end
    endcase
  end

  // Read multiplexer; unmapped addresses read zero.
  wire [31:0] rd_mux =
    (haddr == cps_pkg::ADDR_DIV_CTRL)   ? {24'h000000, unlock_reg, 3'h0, sel_reg} :
    (haddr == cps_pkg::ADDR_SLEEP_CTRL) ? {24'h000000, sleep_reg} :
    (haddr == cps_pkg::ADDR_STATUS)     ? {27'h0000000, state_reg} : 32'h00000000;

  // Fuse level passes two flip-flops and is captured on the third edge after reset release.
  // Loading any earlier would take the second stage's reset value instead of the fuse.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fuse_sync1_reg <= 1'b0;
      fuse_sync2_reg <= 1'b0;
      fuse_wait_reg  <= 2'h0;
      fuse_load_reg  <= 1'b0;
    end else begin
      fuse_sync1_reg <= divide_by_eight_fuse;
      fuse_sync2_reg <= fuse_sync1_reg;
      fuse_wait_reg  <= {fuse_wait_reg[0], 1'b1};
      fuse_load_reg  <= fuse_wait_reg[1];
    end
  end

  // Control registers.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sel_reg    <= cps_pkg::SEL_RST_PLAIN;
      unlock_reg <= 1'b0;
      ucnt_reg   <= 3'h0;
      sleep_reg  <= cps_pkg::SLEEP_RST;
    end else begin
      sel_reg    <= sel_next;
      unlock_reg <= unlock_next;
      ucnt_reg   <= ucnt_next;
      sleep_reg  <= sleep_next;
    end
  end

  // Reset in any state returns the controller to run, so the core restarts from its vector.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= cps_pkg::ST_RUN;
      wcnt_reg  <= 8'h00;
    end else begin
      state_reg <= state_next;
      wcnt_reg  <= wcnt_next;
    end
  end

  // Prescaler counter; stalls in ST_DOWN (power-down or standby) and runs again from start-up on.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_cnt_reg <= 8'h00;
      div_en_reg  <= 1'b0;
    end else if (state_reg == cps_pkg::ST_DOWN) begin
      div_en_reg <= 1'b0;
    end else begin
      div_cnt_reg <= ((div_cnt_reg & mask_now) == mask_now) ? 8'h00 : div_cnt_reg + 8'h01;
      div_en_reg  <= ((div_cnt_reg & mask_now) == mask_now);
    end
  end

  // Bus interface; the slave never inserts wait states.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      addr_reg    <= 8'h00;
      rdata_reg   <= 32'h00000000;
    end else begin
      wr_pend_reg <= bus_go && hwrite;
      addr_reg    <= bus_go ? haddr : addr_reg;
      rdata_reg   <= rd_go ? rd_mux : rdata_reg;
    end
  end

  // Outputs; idle stops only core and flash, deep modes stop I/O too, and the oscillator stops in ST_DOWN unless standby.
  wire asleep = (state_reg != cps_pkg::ST_RUN);
  wire deep   = (state_reg == cps_pkg::ST_DOWN) || (state_reg == cps_pkg::ST_START);
  assign clk_en.cpu   = !asleep;
  assign clk_en.flash = !asleep;
  assign clk_en.io    = !deep;
  assign clk_en.osc   = !(state_reg == cps_pkg::ST_DOWN) || is_standby;
  assign core_halt    = asleep;
  assign clk_div_en   = div_en_reg;
  assign pullup_disable = sleep_reg[cps_pkg::PULLUP_BIT];
  assign hrdata       = rdata_reg;
  assign hreadyout    = 1'b1;
  assign hresp        = 1'b0;

endmodule
`default_nettype wire

/* verif/cps_core_model.sv */
// Model of the core and the wake sources facing the sleep controller.
`default_nettype none
module cps_core_model (
  input  wire logic               hclk,        // Master clock.
  input  wire logic               hresetn,     // Reset, active low.
  input  wire logic               core_halt,   // Core stalled by the block.
  input  wire logic               do_sleep,    // Bench asks for a sleep instruction.
  input  wire cps_pkg::cps_wake_t do_wake,     // Bench asks for wake events.
  output logic                    sleep_instr, // Sleep instruction pulse.
  output cps_pkg::cps_wake_t      wake_req     // Wake request levels.
);
  // A stalled core fetches nothing, so it never issues a sleep instruction then.
  // Each wake level stands one full sampled cycle, which the block needs to see it.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sleep_instr <= 1'b0;
      wake_req    <= '0;
    end else begin
      sleep_instr <= do_sleep & ~core_halt;
      wake_req    <= do_wake;
    end
  end
endmodule
`default_nettype wire

/* verif/cps_top_bench.sv */
// Bench for the prescaler and sleep controller, over its bus and core side.
`default_nettype none
module cps_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] A_DIV = cps_pkg::ADDR_DIV_CTRL;   // Divider control.
  localparam logic [7:0] A_SLP = cps_pkg::ADDR_SLEEP_CTRL; // Sleep control.
  localparam logic [7:0] A_ST  = cps_pkg::ADDR_STATUS;     // State, one-hot.
  logic                 hclk, hresetn, hsel, hwrite, fuse, xtal, do_sleep, sleep_instr, hreadyout, clk_div_en;
  logic                 core_halt;
  logic                 hresp, pullup_disable;
  logic [1:0]           htrans, m;
  logic [7:0]           haddr;
  logic [31:0]          hwdata, hrdata, n;
  cps_pkg::cps_wake_t   do_wake, wake_req;
  cps_pkg::cps_clk_en_t clk_en;
  int                   fails, checks_done;
  // The single slave's ready is the bus ready.
  cps_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .divide_by_eight_fuse(fuse), .ext_crystal_sel(xtal), .startup_cycles(8'h14), .sleep_instr(sleep_instr),
    .wake_req(wake_req), .clk_div_en(clk_div_en), .clk_en(clk_en), .core_halt(core_halt),
    .pullup_disable(pullup_disable));
  cps_core_model core (.hclk(hclk), .hresetn(hresetn), .core_halt(core_halt), .do_sleep(do_sleep),
    .do_wake(do_wake), .sleep_instr(sleep_instr), .wake_req(wake_req));
  // Clock of 100 ns.
  always #50 hclk = ~hclk;
  // Counts a comparison and reports a mismatch.
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One single transfer: address phase held until ready, then data phase until ready.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    bus(1'b1, a, {24'h0, d}, r);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string what);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    check(what, r, e);
  endtask
  // Unlock then select back to back, well inside the window.
  task automatic set_sel(input logic [3:0] s);
    do_wake <= '0;
    wr(A_DIV, 8'h80);
    wr(A_DIV, {4'h0, s});
  endtask
  // Skips the pulse that may be irregular after a change, then counts one period.
  task automatic period(output logic [31:0] p);
    p = 0;
    do @(posedge hclk); while (clk_div_en !== 1'b1);
    do @(posedge hclk); while (clk_div_en !== 1'b1);
    do begin
      @(posedge hclk);
      p++;
    end while (clk_div_en !== 1'b1);
  endtask
  // One-cycle request to the core model, then time for it to land.
  task automatic pulse(input logic s, input cps_pkg::cps_wake_t w);
    @(posedge hclk);
    do_sleep <= s;
    do_wake  <= w;
    @(posedge hclk);
    do_sleep <= 1'b0;
    do_wake  <= '0;
    repeat (3) @(posedge hclk);
  endtask
  task automatic do_reset(input logic f);
    fuse    <= f;
    hresetn <= 1'b0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
  endtask
  task automatic wrap_up();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // A hang is cut off well past the few thousand cycles the tests need.
  initial begin
    repeat (20000) @(posedge hclk);
    fails++;
    wrap_up();
  end
  // Main test sequence.
  initial begin
    {hclk, hsel, htrans, haddr, hwrite, hwdata, xtal, do_sleep, do_wake} = '0;
    hsel = 1'b1;
    fails = 0;
    checks_done = 0;
    do_reset(1'b0);
    rdc(A_DIV, 32'h0, "sel reset");
    rdc(A_SLP, 32'h0, "sleep reset");
    wr(A_DIV, 8'h05);
    wr(A_DIV, 8'h81);
    wr(A_DIV, 8'h05);
    rdc(A_DIV, 32'h0, "locked writes");
    check("ignored write resp", {31'h0, hresp}, 32'h0);
    wr(A_DIV, 8'h80);
    rdc(A_DIV, 32'h80, "unlock open");
    rdc(A_DIV, 32'h0, "unlock expired");
    wr(A_DIV, 8'h80);
    wr(A_DIV, 8'h80);
    wr(A_DIV, 8'h07);
    rdc(A_DIV, 32'h0, "rewrite window");
    wr(A_DIV, 8'h80);
    repeat (3) @(posedge hclk);
    wr(A_DIV, 8'h07);
    rdc(A_DIV, 32'h0, "late select");
    for (int i = 0; i < 10; i++) begin
      set_sel(i[3:0]);
      rdc(A_DIV, 32'(i), "sel stored");
      period(n);
      check("div period", n, (i > 8) ? 32'd256 : 32'd1 << i);
    end
    do_reset(1'b1);
    rdc(A_DIV, 32'h3, "fuse sel");
    period(n);
    check("fuse period", n, 32'd8);
    set_sel(4'h0);
    rdc(A_DIV, 32'h0, "sel over fuse");
    $display("divider tests done");
    wr(A_SLP, 8'hff);
    rdc(A_SLP, 32'h7f, "sleep reg");
    check("pullup read only", {31'h0, pullup_disable}, 32'h0);
    wr(A_SLP, 8'h00);
    pulse(1'b1, '0);
    rdc(A_ST, 32'h1, "no enable");
    for (int i = 0; i < 4; i++) begin
      m = i[1:0];
      wr(A_SLP, {1'b0, m[1], 1'b1, m[0], 4'h0});
      pulse(1'b1, '0);
      rdc(A_ST, (m == 2'h0) ? 32'h2 : 32'h4, "mode");
      check("sleep clocks", {28'h0, clk_en}, (m == 2'h0) ? 32'h3 : 32'h0);
      check("div stall", {31'h0, clk_div_en}, (m == 2'h0) ? 32'h1 : 32'h0);
      if (m == 2'h0) begin
        pulse(1'b0, 6'h02);
      end else begin
        pulse(1'b0, 6'h03);
        rdc(A_ST, 32'h4, "down ignores io");
        pulse(1'b0, 6'h08);
        rdc(A_ST, 32'h8, "start-up");
        repeat (13) @(posedge hclk);
        rdc(A_ST, 32'h8, "start-up length");
        rdc(A_ST, 32'h10, "halt after start-up");
      end
      repeat (30) @(posedge hclk);
      rdc(A_ST, 32'h1, "awake");
      wr(A_SLP, 8'h00);
    end
    xtal <= 1'b1;
    wr(A_SLP, 8'h60);
    pulse(1'b1, '0);
    check("standby clocks", {28'h0, clk_en}, 32'h1);
    pulse(1'b0, 6'h04);
    repeat (12) @(posedge hclk);
    rdc(A_ST, 32'h1, "standby wake");
    wr(A_SLP, 8'h20);
    pulse(1'b1, '0);
    do_reset(1'b0);
    rdc(A_ST, 32'h1, "reset in sleep");
    $display("sleep tests done");
    wrap_up();
  end
endmodule
`default_nettype wire

/* verif/cps_top_sva.sv */
// Checker for the sleep controller's clock enables and wake timing.
`default_nettype none
module cps_top_sva (
  input wire logic                 hclk,        // Master clock.
  input wire logic                 hresetn,     // Reset, active low.
  input wire logic                 sleep_instr, // Sleep instruction pulse.
  input wire cps_pkg::cps_wake_t   wake_req,    // Wake requests.
  input wire cps_pkg::cps_clk_en_t clk_en,      // Clock enables.
  input wire logic                 core_halt    // Core stalled.
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Only these sources may end power-down or standby; the rest must be ignored there.
  wire dn_wake = wake_req.ext_external_interrupt_zero_level | wake_req.pin_change | wake_req.serial_start;
  wire asleep_io = core_halt & clk_en.io;   // Idle or wake halt, I/O clock still running.
  wire asleep_dn = core_halt & ~clk_en.io;  // Power-down or standby, and the start-up after them.
  // The core stays stalled four cycles, then runs.
  sequence halt_four;
    core_halt [*4] ##1 !core_halt;
  endsequence
  // Start-up of six cycles, then the same four-cycle halt.
  sequence standby_wake;
    core_halt [*6] ##1 halt_four;
  endsequence
  a_sleep_needs_instr: assert property ($rose(core_halt) |-> $past(sleep_instr))
    else $error("core halted without a sleep instruction");
  a_idle_wake_halt: assert property ((asleep_io && $rose(|wake_req)) |=> halt_four)
    else $error("idle wake halt length wrong");
  a_standby_six: assert property ((asleep_dn && clk_en.osc && $rose(dn_wake)) |=> standby_wake)
    else $error("standby wake timing wrong");
  a_run_all_clocks: assert property (!core_halt |-> clk_en == 4'hf)
    else $error("clock off while running");
  a_idle_clocks: assert property ((asleep_io && !clk_en.cpu) |-> clk_en.osc && !clk_en.flash)
    else $error("idle clock set wrong");
  a_down_no_core: assert property (asleep_dn |-> !clk_en.cpu && !clk_en.flash)
    else $error("core clock on in power-down");
  a_down_holds: assert property ((asleep_dn && !dn_wake) |=> core_halt)
    else $error("power-down left without wake source");
  a_reset_runs: assert property ($rose(hresetn) |-> !core_halt [*2])
    else $error("not running after reset");
endmodule
bind cps_top cps_top_sva u_sva (.hclk(hclk), .hresetn(hresetn), .sleep_instr(sleep_instr),
  .wake_req(wake_req), .clk_en(clk_en), .core_halt(core_halt));
`default_nettype wire
